// file: bench/antenna_switch_model.sv
module antenna_switch_model (
   input  wire logic       mclk,           // Digital clock
   input  wire logic       antenna_switch, // 0 antenna 1, 1 antenna 2
   input  wire logic [7:0] power_ant1,     // Level arriving on antenna 1
   input  wire logic [7:0] power_ant2,     // Level arriving on antenna 2
   output logic      [7:0] rssi            // Level seen after the switch
);
   timeunit 1ns;
   timeprecision 100ps;

   // The switch answers one clock late, so no new level is seen in the switching cycle
   always_ff @(posedge mclk) begin
      rssi <= antenna_switch ? power_ant2 : power_ant1;
   end
endmodule : antenna_switch_model

// file: bench/rx_quality_antenna_diversity_tb_top.sv
module rx_quality_antenna_diversity_tb_top;
   import rxq_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {
      logic [3:0] pq; logic [2:0] sq; logic en; logic [5:0] len;
      logic [31:0] prim; logic [31:0] sec; logic sec_en; int n; logic [63:0] bits;
      int e_pq; int e_sq; logic chk; logic [7:0] e_rb;
   } row_s;

   logic        mclk, rst, rx_start, rx_active, bit_valid, bit_in, sync_quality_check_enable;
   logic        secondary_sync_enable, cs_blanking, diversity_enable, ook_mode;
   logic        preamble_valid_irq, sync_valid_irq, carrier_sense, rx_data_enable;
   logic        antenna_switch;
   logic [7:0]  rssi, rssi_threshold, sync_quality_readback, power_ant1, power_ant2;
   logic [3:0]  preamble_quality_threshold, channel_filter_setting;
   logic [2:0]  sync_quality_threshold, diversity_measure_time;
   logic [5:0]  sync_word_length;
   logic [31:0] sync_word_primary, sync_word_secondary;
   logic [1:0]  main_controller_state;
   int          n_mismatch, checks_done, n_pre, n_sync;
   row_s        rows[15];

   rx_quality_antenna_diversity i_rx_quality_antenna_diversity (
      .mclk(mclk), .rst(rst), .rx_start(rx_start), .rx_active(rx_active),
      .bit_valid(bit_valid), .bit_in(bit_in), .rssi(rssi),
      .preamble_quality_threshold(preamble_quality_threshold),
      .sync_quality_threshold(sync_quality_threshold),
      .sync_quality_check_enable(sync_quality_check_enable),
      .sync_word_length(sync_word_length), .sync_word_primary(sync_word_primary),
      .sync_word_secondary(sync_word_secondary), .secondary_sync_enable(secondary_sync_enable),
      .rssi_threshold(rssi_threshold), .cs_blanking(cs_blanking),
      .diversity_enable(diversity_enable), .diversity_measure_time(diversity_measure_time),
      .channel_filter_setting(channel_filter_setting), .ook_mode(ook_mode),
      .preamble_valid_irq(preamble_valid_irq), .sync_valid_irq(sync_valid_irq),
      .sync_quality_readback(sync_quality_readback),
      .main_controller_state(main_controller_state), .carrier_sense(carrier_sense),
      .rx_data_enable(rx_data_enable), .antenna_switch(antenna_switch));

   antenna_switch_model i_antenna_switch_model (
      .mclk(mclk), .antenna_switch(antenna_switch), .power_ant1(power_ant1),
      .power_ant2(power_ant2), .rssi(rssi));

   // Clock at 200 MHz
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   // Interrupts are single-cycle pulses, so count them mid-cycle rather than poll them
   always @(negedge mclk) begin
      if (preamble_valid_irq === 1'b1) n_pre++;
      if (sync_valid_irq === 1'b1) n_sync++;
   end

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   task automatic start_rx;
      n_pre = 0;
      n_sync = 0;
      rx_start = 1'b1;
      @(negedge mclk);
      rx_start = 1'b0;
   endtask : start_rx

   // Counts edges from enable to the first switch change
   task automatic div_time(logic [3:0] e, logic [2:0] t, logic ook, int exp);
      logic s;
      int   n;
      diversity_enable = 1'b0;
      channel_filter_setting = e;
      diversity_measure_time = t;
      ook_mode = ook;
      start_rx;
      @(negedge mclk);
      s = antenna_switch;
      n = 0;
      diversity_enable = 1'b1;
      while (antenna_switch === s && n < 3000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("switch interval", n, exp);
      check("state mirror", main_controller_state[1], antenna_switch);
      @(negedge mclk);
   endtask : div_time

   // Watchdog well beyond the expected run of some 1800 cycles
   initial begin
      #100us;
      n_mismatch++;
      stop_test;
   end

   initial begin
      logic [7:0] cs_p[6] = '{8'h64, 8'h65, 8'h62, 8'h61, 8'h60, 8'h63};
      logic       cs_b[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      logic       cs_e[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      logic       en_e[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      logic       s;
      rows = '{
         '{4'h0, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 4, 64'hF, 0, 0, 1'b0, 8'h00},
         '{4'h0, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 4, 64'h7, 1, 0, 1'b0, 8'h00},
         '{4'h1, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 5, 64'h15, 0, 0, 1'b0, 8'h00},
         '{4'h1, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 6, 64'h15, 1, 0, 1'b0, 8'h00},
         '{4'h2, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 14, 64'h2B55, 0, 0, 1'b0, 8'h00},
         '{4'h2, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 15, 64'h2B55, 1, 0, 1'b0, 8'h00},
         '{4'hF, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 61, {4{16'h5555}}, 0, 0, 1'b0, 8'h00},
         '{4'hF, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 62, {4{16'h5555}}, 1, 0, 1'b0, 8'h00},
         '{4'h0, 3'h0, 1'b1, 6'h00, 32'h0, 32'h0, 1'b0, 20, 64'h55555, 1, 0, 1'b0, 8'h00},
         '{4'hF, 3'h0, 1'b1, 6'h08, 32'hFF, 32'h0, 1'b0, 8, 64'hFF, 0, 1, 1'b1, 8'h08},
         '{4'hF, 3'h0, 1'b1, 6'h08, 32'hFF, 32'h0, 1'b0, 8, 64'h7F, 0, 0, 1'b1, 8'h07},
         '{4'hF, 3'h1, 1'b1, 6'h08, 32'hFF, 32'h0, 1'b0, 8, 64'h7F, 0, 1, 1'b1, 8'h07},
         '{4'hF, 3'h0, 1'b0, 6'h08, 32'hFF, 32'h0, 1'b0, 8, 64'hFF, 0, 0, 1'b1, 8'h08},
         '{4'hF, 3'h0, 1'b1, 6'h08, 32'hFF, 32'hF0, 1'b1, 8, 64'h0F, 0, 1, 1'b1, 8'h48},
         '{4'hF, 3'h7, 1'b1, 6'h20, 32'hFFFFFFFF, 32'h0, 1'b0, 32, 64'hFFFFFFFF, 0, 1, 1'b1, 8'h20}};
      rst = 1'b1; rx_start = 1'b0; rx_active = 1'b1; bit_valid = 1'b0; bit_in = 1'b0;
      sync_quality_check_enable = 1'b1;
      secondary_sync_enable = 1'b0; cs_blanking = 1'b0; diversity_enable = 1'b0;
      ook_mode = 1'b0; rssi_threshold = 8'h64; power_ant1 = 8'h32; power_ant2 = 8'h32;
      preamble_quality_threshold = 4'h0; channel_filter_setting = 4'h0;
      sync_quality_threshold = 3'h0; diversity_measure_time = 3'h0;
      sync_word_length = 6'h00; sync_word_primary = 32'h0; sync_word_secondary = 32'h0;
      n_mismatch = 0; checks_done = 0; n_pre = 0; n_sync = 0;
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      // Values held through reset
      check("reset readback", sync_quality_readback, 8'h00);
      check("reset outputs", {preamble_valid_irq, sync_valid_irq, main_controller_state,
            carrier_sense, rx_data_enable, antenna_switch}, 7'h02);
      // Bit stream rows
      foreach (rows[i]) begin
         preamble_quality_threshold = rows[i].pq;
         sync_quality_threshold = rows[i].sq;
         sync_quality_check_enable = rows[i].en;
         sync_word_length = rows[i].len;
         sync_word_primary = rows[i].prim;
         sync_word_secondary = rows[i].sec;
         secondary_sync_enable = rows[i].sec_en;
         start_rx;
         for (int k = 0; k < rows[i].n; k++) begin
            bit_valid = 1'b1;
            bit_in = rows[i].bits[k];
            @(negedge mclk);
         end
         bit_valid = 1'b0;
         repeat (4) @(negedge mclk);
         check("preamble irq count", n_pre, rows[i].e_pq);
         check("sync irq count", n_sync, rows[i].e_sq);
         if (rows[i].chk) check("sync readback", sync_quality_readback, rows[i].e_rb);
      end
      sync_quality_check_enable = 1'b1;
      // Carrier sense hysteresis and blanking around a threshold of 100
      foreach (cs_p[i]) begin
         power_ant1 = cs_p[i];
         power_ant2 = cs_p[i];
         cs_blanking = cs_b[i];
         repeat (3) @(negedge mclk);
         check("carrier sense", carrier_sense, cs_e[i]);
         check("data enable", rx_data_enable, en_e[i]);
      end
      cs_blanking = 1'b0;
      power_ant1 = 8'h32;
      power_ant2 = 8'h32;
      repeat (3) @(negedge mclk);
      // Diversity stays static mode here, the only mode the block has
      div_time(4'h0, 3'h0, 1'b0, 25);
      div_time(4'h0, 3'h1, 1'b0, 49);
      div_time(4'h1, 3'h1, 1'b0, 97);
      div_time(4'h0, 3'h0, 1'b1, 49);
      div_time(4'h1, 3'h0, 1'b1, 97);
      // Freeze on the stronger antenna, both ways round
      channel_filter_setting = 4'h0;
      ook_mode = 1'b0;
      for (int j = 0; j < 2; j++) begin
         diversity_enable = 1'b0;
         power_ant1 = j ? 8'h78 : 8'h32;
         power_ant2 = j ? 8'h32 : 8'h78;
         start_rx;
         diversity_enable = 1'b1;
         repeat (300) @(negedge mclk);
         check("frozen antenna", antenna_switch, !j);
         repeat (100) @(negedge mclk);
         check("still frozen", antenna_switch, !j);
         check("state mirror", main_controller_state[1], !j);
      end
      // Disabled diversity leaves the switch alone
      diversity_enable = 1'b0;
      power_ant1 = 8'h32;
      power_ant2 = 8'h32;
      start_rx;
      s = antenna_switch;
      repeat (200) @(negedge mclk);
      check("switch held", antenna_switch, s);
      // Outside receive, bits are ignored and the diversity search stays parked
      rx_active = 1'b0;
      diversity_enable = 1'b1;
      preamble_quality_threshold = 4'h0;
      start_rx;
      s = antenna_switch;
      for (int k = 0; k < 8; k++) begin
         bit_valid = 1'b1;
         bit_in = k[0];
         @(negedge mclk);
      end
      bit_valid = 1'b0;
      repeat (60) @(negedge mclk);
      check("idle irq count", n_pre, 0);
      check("idle switch", antenna_switch, s);
      stop_test;
   end
endmodule : rx_quality_antenna_diversity_tb_top

// file: src/rx_quality_antenna_diversity.sv
// How it works
// [R1] Preamble score adds 1 on a bit inversion, subtracts 4 on a repetition.
// [R2] Running peak of preamble score raises preamble-valid once it passes threshold.
// [R3] Preamble threshold is four times the 4-bit setting.
// [R4] Sync score is peak bitwise correlation of stream against expected sync word.
// [R5] With check enabled, sync-valid rises once peak sync score reaches threshold.
// [R6] Sync threshold is word length minus twice setting; zero means exact match.
// [R7] Software should keep the sync quality check enabled always.
// [R8] Peak sync score readable in bits 5..0, range 0 to 32.
// [R9] Bit 6 of sync readback flags that the peak came from the secondary word.
// [R10] Carrier-sense blanking blocks received data while RSSI is below threshold.
// [R11] Diversity compares antenna 1 and 2 power, switch picks the stronger one.
// [R12] Antennas alternate during preamble until carrier sense, then freeze on stronger.
// [R13] Software must choose static carrier sense whenever diversity is enabled.
// [R14] Switch control drives an output pin and bit 1 of state readback.
// [R15] Measurement interval is 24 clocks shifted by filter exponent and time setting.
// [R16] FSK: whole interval settles, one power sample taken at its end.
// [R17] OOK: one interval settles, a second interval records peak power.
// [R18] Diversity runs only while its enable input is set.
// [R19] Static carrier sense sets above threshold, clears more than 3 dB below it.
// [R20] Preamble score floors at zero; scores and peaks clear on receive entry.
module rx_quality_antenna_diversity
   import rxq_pkg::*;
#(
   parameter int TIMER_W = 24                              // Measurement timer width
) (
   input  wire logic        mclk,                          // Digital clock, 200 MHz
   input  wire logic        rst,                           // Synchronous reset, active high
   input  wire logic        rx_start,                      // Pulse on entry into receive
   input  wire logic        rx_active,                     // High while in receive
   input  wire logic        bit_valid,                     // Demodulated bit strobe
   input  wire logic        bit_in,                        // Demodulated bit
   input  wire logic [7:0]  rssi,                          // Filtered RSSI, 1 dB steps
   input  wire logic [3:0]  preamble_quality_threshold,    // Preamble threshold setting
   input  wire logic [2:0]  sync_quality_threshold,        // Sync threshold setting
   input  wire logic        sync_quality_check_enable,     // Enables sync-valid
   input  wire logic [5:0]  sync_word_length,              // Sync length in bits
   input  wire logic [31:0] sync_word_primary,             // Expected primary word
   input  wire logic [31:0] sync_word_secondary,           // Expected secondary word
   input  wire logic        secondary_sync_enable,         // Also search secondary word
   input  wire logic [7:0]  rssi_threshold,                // Carrier sense threshold
   input  wire logic        cs_blanking,                   // Blank data below threshold
   input  wire logic        diversity_enable,              // Antenna switching on
   input  wire logic [2:0]  diversity_measure_time,        // Interval exponent
   input  wire logic [3:0]  channel_filter_setting,        // Channel filter exponent E
   input  wire logic        ook_mode,                      // 1 OOK, 0 FSK
   output logic             preamble_valid_irq,            // One-cycle pulse
   output logic             sync_valid_irq,                // One-cycle pulse
   output logic [7:0]       sync_quality_readback,         // Peak score and word flag
   output logic [1:0]       main_controller_state,         // Bit 1 mirrors the switch
   output logic             carrier_sense,                 // Static carrier sense
   output logic             rx_data_enable,                // Low while blanked
   output logic             antenna_switch                 // Switch drive to GPIO
);

   typedef struct packed {
      logic [7:0]         pq_cnt;
      logic [7:0]         pq_peak;
      logic               prev_bit;
      logic               have_prev;
      logic               pq_done;
      logic               pq_irq;
      logic [31:0]        shreg;
      logic [5:0]         bit_cnt;
      logic [5:0]         sq_peak;
      logic               sq_sec;
      logic               sq_done;
      logic               sq_irq;
      logic               cs;
      logic               rx_en;
      div_state_e         dstate;
      logic               ant;
      logic [TIMER_W-1:0] timer;
      logic [7:0]         pk;
      logic [7:0]         pow0;
      logic [7:0]         pow1;
      logic [1:0]         seen;
   } state_s;

   state_s q;
   state_s d;

   // Bitwise agreement over the newest len bits; shreg[0] is the newest bit
   function automatic logic [5:0] corr(input logic [31:0] sh,
                                       input logic [31:0] w,
                                       input logic [5:0]  len);
      logic [5:0] n;
      n = SQ_RESET;
      for (int i = 0; i < SYNC_BITS; i++) begin
         if (i < int'(len) && sh[i] == w[i]) begin
            n = n + 6'h01;
         end
      end
      return n;
   endfunction : corr

   // Derived thresholds; sync length above 32 is treated as 32
   logic [7:0]         pq_thr;
   logic [5:0]         sq_len;
   logic [5:0]         sq_thr;
   logic [5:0]         corr_p;
   logic [5:0]         corr_s;
   logic [TIMER_W-1:0] meas_lim;
   logic [8:0]         rssi_hyst;

   assign pq_thr    = {2'h0, preamble_quality_threshold, 2'h0};                  // [R3]
   assign sq_len    = (sync_word_length > SQ_MAX) ? SQ_MAX : sync_word_length;
   assign sq_thr    = (sq_len > {2'h0, sync_quality_threshold, 1'b0}) ?          // [R6]
                      sq_len - {2'h0, sync_quality_threshold, 1'b0} : SQ_RESET;
   assign corr_p    = corr(q.shreg, sync_word_primary, sq_len);                  // [R4]
   assign corr_s    = corr(q.shreg, sync_word_secondary, sq_len);
   // Shift exponent total reaches 22, so 24 << 22 is truncated to the 24-bit timer width
   assign meas_lim  = TIMER_W'(MEAS_BASE_CYCLES)
                      << channel_filter_setting << diversity_measure_time;       // [R15]
   assign rssi_hyst = {1'b0, rssi} + CS_HYST_DB;

   // Next-state logic for scoring, carrier sense and the diversity sequencer
   always_comb begin
      logic [7:0] sample;
      logic       meas_end;
      logic [5:0] best;
      logic       best_sec;
      sample   = RSSI_RESET;
      meas_end = 1'b0;
      best     = SQ_RESET;
      best_sec = 1'b0;
      d        = q;
      d.pq_irq = 1'b0;
      d.sq_irq = 1'b0;

      // Preamble score on each bit, floored at zero and held at the top
      if (rx_active && bit_valid) begin
         d.prev_bit  = bit_in;
         d.have_prev = 1'b1;
         if (q.have_prev && bit_in != q.prev_bit) begin
            d.pq_cnt = (q.pq_cnt == PQ_MAX) ? PQ_MAX : q.pq_cnt + PQ_STEP_UP;    // [R1]
         end else if (q.have_prev) begin
            d.pq_cnt = (q.pq_cnt < PQ_STEP_DOWN) ? PQ_RESET                      // [R20]
                                                 : q.pq_cnt - PQ_STEP_DOWN;      // [R1]
         end
         if (d.pq_cnt > q.pq_peak) begin
            d.pq_peak = d.pq_cnt;                                                 // [R2]
         end
         if (!q.pq_done && d.pq_peak > pq_thr) begin
            d.pq_irq  = 1'b1;                                                     // [R2]
            d.pq_done = 1'b1;
         end

         // Sync correlation once a full word of bits has arrived
         d.shreg   = {q.shreg[30:0], bit_in};
         d.bit_cnt = (q.bit_cnt == SQ_MAX) ? SQ_MAX : q.bit_cnt + 6'h01;
      end

      // Peak tracking runs on the registered window, one cycle after the shift
      if (rx_active && q.bit_cnt >= sq_len) begin
         best     = corr_p;
         best_sec = 1'b0;
         if (secondary_sync_enable && corr_s > corr_p) begin
            best     = corr_s;
            best_sec = 1'b1;                                                      // [R9]
         end
         if (best > q.sq_peak) begin
            d.sq_peak = best;                                                     // [R4]
            d.sq_sec  = best_sec;
         end
      end
      if (sync_quality_check_enable && !q.sq_done && q.bit_cnt >= sq_len
          && d.sq_peak >= sq_thr && sq_len != SQ_RESET) begin
         d.sq_irq  = 1'b1;                                                        // [R5]
         d.sq_done = 1'b1;
      end

      // Static carrier sense with 3 dB release hysteresis
      if (rssi > rssi_threshold) begin
         d.cs = 1'b1;                                                             // [R19]
      end else if (rssi_hyst < {1'b0, rssi_threshold}) begin
         d.cs = 1'b0;                                                             // [R19]
      end
      d.rx_en = !(cs_blanking && rssi < rssi_threshold);                          // [R10]

      // Diversity sequencer; leaving receive or disabling parks it
      case (q.dstate)
         DIV_IDLE: begin
            d.timer = TIMER_RESET;
            if (diversity_enable && rx_active) begin
               d.dstate = DIV_SETTLE;                                             // [R18]
            end
         end
         DIV_SETTLE: begin
            d.timer = q.timer + TIMER_W'(1);
            if (q.timer >= meas_lim - TIMER_W'(1)) begin
               d.timer = TIMER_RESET;
               if (ook_mode) begin
                  d.dstate = DIV_PEAK;                                            // [R17]
                  d.pk     = rssi;
               end else begin
                  sample   = rssi;                                                // [R16]
                  meas_end = 1'b1;
               end
            end
         end
         DIV_PEAK: begin
            d.timer = q.timer + TIMER_W'(1);
            d.pk    = (rssi > q.pk) ? rssi : q.pk;                                // [R17]
            if (q.timer >= meas_lim - TIMER_W'(1)) begin
               d.timer  = TIMER_RESET;
               sample   = d.pk;
               meas_end = 1'b1;
            end
         end
         DIV_FROZEN: begin
            d.timer = TIMER_RESET;
         end
         default: begin
            d.dstate = DIV_IDLE;
         end
      endcase

      // Close one antenna measurement: freeze on the stronger or swap antennas
      if (meas_end) begin
         if (q.ant) begin
            d.pow1 = sample;                                                      // [R11]
         end else begin
            d.pow0 = sample;                                                      // [R11]
         end
         d.seen[q.ant] = 1'b1;
         if (q.cs && d.seen == 2'b11) begin
            d.dstate = DIV_FROZEN;                                                // [R12]
            d.ant    = (d.pow1 > d.pow0);                                         // [R11]
         end else begin
            d.dstate = DIV_SETTLE;
            d.ant    = !q.ant;                                                    // [R12]
         end
      end
      if (!diversity_enable || !rx_active) begin
         d.dstate = DIV_IDLE;                                                     // [R18]
         d.timer  = TIMER_RESET;
         // A measurement closing in the same cycle must not move the switch
         d.ant    = q.ant;                                                        // [R18]
      end

      // Entry into receive restarts every score and the diversity search
      if (rx_start) begin
         d.pq_cnt    = PQ_RESET;                                                  // [R20]
         d.pq_peak   = PQ_RESET;                                                  // [R20]
         d.have_prev = 1'b0;
         d.pq_done   = 1'b0;
         d.pq_irq    = 1'b0;
         d.bit_cnt   = SQ_RESET;
         d.sq_peak   = SQ_RESET;                                                  // [R20]
         d.sq_sec    = 1'b0;
         d.sq_done   = 1'b0;
         d.sq_irq    = 1'b0;
         d.seen      = 2'b00;
         d.dstate    = DIV_IDLE;
         d.timer     = TIMER_RESET;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         q.pq_cnt    <= PQ_RESET;
         q.pq_peak   <= PQ_RESET;
         q.prev_bit  <= 1'b0;
         q.have_prev <= 1'b0;
         q.pq_done   <= 1'b0;
         q.pq_irq    <= 1'b0;
         q.shreg     <= 32'h00000000;
         q.bit_cnt   <= SQ_RESET;
         q.sq_peak   <= SQ_RESET;
         q.sq_sec    <= 1'b0;
         q.sq_done   <= 1'b0;
         q.sq_irq    <= 1'b0;
         q.cs        <= 1'b0;
         q.rx_en     <= 1'b1;
         q.dstate    <= DIV_IDLE;
         q.ant       <= 1'b0;
         q.timer     <= TIMER_RESET;
         q.pk        <= RSSI_RESET;
         q.pow0      <= RSSI_RESET;
         q.pow1      <= RSSI_RESET;
         q.seen      <= 2'b00;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from the state register
   assign preamble_valid_irq    = q.pq_irq;
   assign sync_valid_irq        = q.sq_irq;
   assign sync_quality_readback = {1'b0, q.sq_sec, q.sq_peak};                    // [R8]
   assign main_controller_state = {q.ant, 1'b0};                                  // [R14]
   assign carrier_sense         = q.cs;
   assign rx_data_enable        = q.rx_en;
   assign antenna_switch        = q.ant;                                          // [R14]

   // Checks beside the logic they guard
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_pq_inversion_up: assert property (                                           // [R1]
      rx_active && bit_valid && !rx_start && q.have_prev && bit_in != q.prev_bit
      && q.pq_cnt != PQ_MAX |=> q.pq_cnt == $past(q.pq_cnt) + PQ_STEP_UP)
      else $error("preamble score did not rise by one");
   a_pq_repeat_down: assert property (                                            // [R1]
      rx_active && bit_valid && !rx_start && q.have_prev && bit_in == q.prev_bit
      |=> q.pq_cnt == (($past(q.pq_cnt) < PQ_STEP_DOWN) ? PQ_RESET
                        : $past(q.pq_cnt) - PQ_STEP_DOWN))
      else $error("preamble score did not fall by four");
   a_pq_irq_cause: assert property (                                              // [R2]
      preamble_valid_irq |-> q.pq_peak > $past(pq_thr) && !$past(q.pq_done))
      else $error("preamble valid without peak above threshold");
   a_sq_irq_gate: assert property (                                               // [R5]
      sync_valid_irq |-> $past(sync_quality_check_enable) && q.sq_peak >= $past(sq_thr))
      else $error("sync valid while check disabled or below threshold");
   a_sq_peak_range: assert property (                                             // [R8]
      sync_quality_readback[5:0] <= SQ_MAX && !sync_quality_readback[7])
      else $error("sync readback out of range");
   a_cs_hold_band: assert property (                                              // [R19]
      q.cs && rssi_hyst >= {1'b0, rssi_threshold} |=> carrier_sense)
      else $error("carrier sense dropped inside hysteresis band");
   a_blank_low_rssi: assert property (                                            // [R10]
      cs_blanking && rssi < rssi_threshold |=> !rx_data_enable)
      else $error("data not blanked below threshold");
   a_ant_mirror: assert property (                                                // [R14]
      main_controller_state[STATE_ANT_BIT] == antenna_switch)
      else $error("state readback does not mirror switch");
   a_div_disabled: assert property (                                              // [R18]
      !diversity_enable && !$past(diversity_enable) |-> $stable(antenna_switch))
      else $error("antenna switched while diversity disabled");
   a_frozen_hold: assert property (                                               // [R12]
      q.dstate == DIV_FROZEN && diversity_enable && rx_active && !rx_start
      |=> $stable(antenna_switch))
      else $error("antenna moved after freeze");

   c_preamble_valid: cover property (preamble_valid_irq);
   c_sync_valid:     cover property (sync_valid_irq);
   c_div_frozen:     cover property (q.dstate == DIV_SETTLE ##1 q.dstate == DIV_FROZEN);
   c_sync_secondary: cover property (sync_quality_readback[SQ_SECONDARY_BIT]);

endmodule : rx_quality_antenna_diversity

// file: src/rxq_pkg.sv
package rxq_pkg;

   // Preamble quality scoring
   localparam logic [7:0] PQ_STEP_UP       = 8'h01;   // Added on a bit inversion
   localparam logic [7:0] PQ_STEP_DOWN     = 8'h04;   // Removed on a bit repetition
   localparam int         PQ_THR_SHIFT     = 2;       // Threshold is setting times four
   localparam logic [7:0] PQ_RESET         = 8'h00;
   localparam logic [7:0] PQ_MAX           = 8'hFF;

   // Sync word correlation
   localparam int         SYNC_BITS        = 32;      // Longest sync word in bits
   localparam logic [5:0] SQ_MAX           = 6'h20;   // Peak correlation ceiling
   localparam logic [5:0] SQ_RESET         = 6'h00;
   localparam int         SQ_SECONDARY_BIT = 6;       // Readback flag position
   localparam int         STATE_ANT_BIT    = 1;       // Antenna bit in state readback

   // Carrier sense hysteresis in RSSI steps of 1 dB
   localparam logic [8:0] CS_HYST_DB       = 9'h003;

   // Diversity measurement base interval in digital clock periods
   localparam logic [23:0] MEAS_BASE_CYCLES = 24'h000018;
   localparam logic [23:0] TIMER_RESET      = 24'h000000;
   localparam logic [7:0]  RSSI_RESET       = 8'h00;

   // Diversity sequencer states
   typedef enum logic [3:0] {
      DIV_IDLE   = 4'b0001,
      DIV_SETTLE = 4'b0010,
      DIV_PEAK   = 4'b0100,
      DIV_FROZEN = 4'b1000
   } div_state_e;

endpackage : rxq_pkg
